// *** smai_attr_decode.sv ***
`timescale 1ns/1ps
module smai_attr_decode (
    smai_attr_if.dec  a
);

    wire [3:0] hi_nib = a.attr_byte[7:4];
    wire [3:0] lo_nib = a.attr_byte[3:0];

    function automatic smai_pkg::smai_cpol_e nib_pol(input logic [3:0] n);
        if (n == smai_pkg::NIB_NONCACH) begin
            nib_pol = smai_pkg::SMAI_CP_NC;
        end else if (n[3] == 1'b0 && n[1:0] == 2'b00) begin
            // RW of zero in the transient rows is unsupported
            nib_pol = smai_pkg::SMAI_CP_NONE;
        end else begin
            nib_pol = n[2] ? smai_pkg::SMAI_CP_WB : smai_pkg::SMAI_CP_WT;
        end
    endfunction

    // =====================================================
    // Outer and inner policy
    wire smai_pkg::smai_cpol_e outer_w = nib_pol(hi_nib);
    wire smai_pkg::smai_cpol_e inner_w = nib_pol(lo_nib);
    wire is_dev = (hi_nib == smai_pkg::NIB_ZERO);

    assign a.outer_pol       = is_dev ? smai_pkg::SMAI_CP_NONE : outer_w;
    assign a.inner_pol       = is_dev ? smai_pkg::SMAI_CP_NONE : inner_w;
    // Transience is only a hint passed on to the memory system
    assign a.outer_transient = !is_dev && !hi_nib[3] &&
                               (outer_w != smai_pkg::SMAI_CP_NC);
    assign a.inner_transient = !is_dev && !lo_nib[3] &&
                               (inner_w != smai_pkg::SMAI_CP_NC);
    assign a.outer_alloc     = is_dev ? 2'b00 : hi_nib[1:0];
    assign a.inner_alloc     = is_dev ? 2'b00 : lo_nib[1:0];

    // =====================================================
    // Memory type
    smai_pkg::smai_mem_type_e dev_type;
    always_comb begin
        case (lo_nib)
            smai_pkg::NIB_ZERO:    dev_type = smai_pkg::SMAI_MEM_DEV_STRICT;
            smai_pkg::NIB_NONCACH: dev_type = smai_pkg::SMAI_MEM_DEV_EARLY;
            smai_pkg::NIB_DEV_RO:  dev_type = smai_pkg::SMAI_MEM_DEV_REORDER;
            smai_pkg::NIB_DEV_GRO: dev_type = smai_pkg::SMAI_MEM_DEV_GATHER;
            default:               dev_type = smai_pkg::SMAI_MEM_UNPRED;
        endcase
    end

    wire norm_bad = (outer_w == smai_pkg::SMAI_CP_NONE) ||
                    (lo_nib == smai_pkg::NIB_ZERO) ||
                    (inner_w == smai_pkg::SMAI_CP_NONE);

    assign a.mem_type = is_dev ? dev_type :
                        norm_bad ? smai_pkg::SMAI_MEM_UNPRED :
                        smai_pkg::SMAI_MEM_NORMAL;

endmodule

// *** smai_attr_if.sv ***
`timescale 1ns/1ps
interface smai_attr_if;
    logic [7:0]                  attr_byte;
    smai_pkg::smai_mem_type_e    mem_type;
    smai_pkg::smai_cpol_e        outer_pol;
    smai_pkg::smai_cpol_e        inner_pol;
    logic                        outer_transient;
    logic                        inner_transient;
    logic [1:0]                  outer_alloc;
    logic [1:0]                  inner_alloc;

    modport top (output attr_byte,
                 input  mem_type, outer_pol, inner_pol,
                 input  outer_transient, inner_transient,
                 input  outer_alloc, inner_alloc);
    modport dec (input  attr_byte,
                 output mem_type, outer_pol, inner_pol,
                 output outer_transient, inner_transient,
                 output outer_alloc, inner_alloc);
endinterface

// *** smai_ctx_bank.sv ***
`timescale 1ns/1ps
module smai_ctx_bank (
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    input  wire logic [11:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic [2:0]  i_attr_select_index,
    output logic      [2:0]  o_mem_type,
    output logic      [1:0]  o_outer_pol,
    output logic      [1:0]  o_inner_pol,
    output logic             o_outer_transient,
    output logic             o_inner_transient,
    output logic      [1:0]  o_outer_alloc,
    output logic      [1:0]  o_inner_alloc,
    output logic             o_xlat_req,
    output logic      [63:0] o_xlat_addr,
    input  wire logic        i_xlat_done,
    input  wire logic [63:0] i_xlat_result,
    output logic             o_extended_address_enable
);

    // =====================================================
    // Registers
    logic [31:0] attr_low_q;
    logic [31:0] attr_high_q;
    logic [31:0] aux_q;
    logic [31:0] xlat_ctrl_q;
    logic [63:0] phys_result_q;
    logic [63:0] xaddr_q;
    smai_pkg::smai_xlat_state_e st_q;
    smai_pkg::smai_xlat_state_e st_d;

    wire wr_low   = i_wr && (i_addr == smai_pkg::ADDR_ATTR_LOW);
    wire wr_high  = i_wr && (i_addr == smai_pkg::ADDR_ATTR_HIGH);
    wire wr_aux   = i_wr && (i_addr == smai_pkg::ADDR_AUX_CTRL);
    wire wr_xctrl = i_wr && (i_addr == smai_pkg::ADDR_XLAT_CTRL);
    wire wr_trig  = i_wr && (i_addr == smai_pkg::ADDR_TRIG_LO);
    wire ext_addr_en = xlat_ctrl_q[smai_pkg::EXT_ADDR_BIT];
    wire active   = (st_q != smai_pkg::SMAI_XS_IDLE);
    // Trigger taken only when idle, so one result lands per trigger
    wire start    = wr_trig && !active;

    always_ff @(posedge i_core_clk) begin
        if (wr_low)  attr_low_q  <= i_wdata;
        if (wr_high) attr_high_q <= i_wdata;
        if (wr_aux)  aux_q       <= i_wdata;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            xlat_ctrl_q <= smai_pkg::RST_WORD;
        end else if (wr_xctrl) begin
            xlat_ctrl_q <= i_wdata;
        end
    end

    // =====================================================
    // Address translation trigger
    // Older format fills the same bits, so both arms match
    wire [63:0] trig_addr = ext_addr_en ?
        {32'h0000_0000, i_wdata[31:smai_pkg::ADDR_LSB],
         12'h000} :
        {32'h0000_0000, i_wdata[31:smai_pkg::ADDR_LSB],
         12'h000};

    always_comb begin
        case (st_q)
            smai_pkg::SMAI_XS_IDLE:
                st_d = start ? smai_pkg::SMAI_XS_BUSY : smai_pkg::SMAI_XS_IDLE;
            smai_pkg::SMAI_XS_BUSY:
                st_d = i_xlat_done ? smai_pkg::SMAI_XS_DONE
                                   : smai_pkg::SMAI_XS_BUSY;
            smai_pkg::SMAI_XS_DONE:
                st_d = smai_pkg::SMAI_XS_IDLE;
            default:
                st_d = smai_pkg::SMAI_XS_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st_q    <= smai_pkg::SMAI_XS_IDLE;
            xaddr_q       <= {2{smai_pkg::RST_WORD}};
            phys_result_q <= {2{smai_pkg::RST_WORD}};
        end else begin
            st_q <= st_d;
            if (start) begin
                xaddr_q <= trig_addr;
            end
            if (st_q == smai_pkg::SMAI_XS_BUSY && i_xlat_done) begin
                phys_result_q <= i_xlat_result;
            end
        end
    end

    assign o_xlat_req  = (st_q == smai_pkg::SMAI_XS_BUSY);
    assign o_xlat_addr = xaddr_q;
    assign o_extended_address_enable = ext_addr_en;

    // =====================================================
    // Attribute selection
    smai_attr_if ai ();

    wire [31:0] sel_reg = i_attr_select_index[smai_pkg::IDX_HI_BIT] ?
                          attr_high_q : attr_low_q;
    assign ai.attr_byte = sel_reg[{i_attr_select_index[1:0], 3'b000} +:
                                  smai_pkg::BYTE_W];

    smai_attr_decode u_dec (
        .a (ai.dec)
    );

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_mem_type        <= 3'h0;
            o_outer_pol       <= 2'h0;
            o_inner_pol       <= 2'h0;
            o_outer_transient <= 1'b0;
            o_inner_transient <= 1'b0;
            o_outer_alloc     <= 2'h0;
            o_inner_alloc     <= 2'h0;
        end else begin
            o_mem_type        <= ai.mem_type;
            o_outer_pol       <= ai.outer_pol;
            o_inner_pol       <= ai.inner_pol;
            o_outer_transient <= ai.outer_transient;
            o_inner_transient <= ai.inner_transient;
            o_outer_alloc     <= ai.outer_alloc;
            o_inner_alloc     <= ai.inner_alloc;
        end
    end

    // =====================================================
    // Read port
    logic [31:0] rd_d;
    always_comb begin
        case (i_addr)
            smai_pkg::ADDR_ATTR_LOW:  rd_d = attr_low_q;
            smai_pkg::ADDR_ATTR_HIGH: rd_d = attr_high_q;
            smai_pkg::ADDR_AUX_CTRL:  rd_d = aux_q;
            smai_pkg::ADDR_XLAT_CTRL: rd_d = xlat_ctrl_q;
            smai_pkg::ADDR_RESULT_LO: rd_d = phys_result_q[31:0];
            smai_pkg::ADDR_RESULT_HI: rd_d = phys_result_q[63:32];
            smai_pkg::ADDR_XLAT_STATUS:
                rd_d = {31'h0, active};
            default:                  rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= i_rd ? rd_d : 32'h0000_0000;
        end
    end

endmodule

// *** smai_ctx_bank_props.sv ***
`timescale 1ns/1ps
module smai_ctx_bank_props (
    input wire logic        i_core_clk,
    input wire logic        i_srst,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [2:0]  o_mem_type,
    input wire logic [1:0]  o_outer_pol,
    input wire logic [1:0]  o_outer_alloc,
    input wire logic [1:0]  o_inner_alloc,
    input wire logic        o_xlat_req,
    input wire logic [63:0] o_xlat_addr,
    input wire logic        i_xlat_done
);
    // ==========================================
    // Walk request, status read, trigger read and device attribute checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // The cycle after done is still the done state, so writes are refused
    sequence s_trig(a);
        i_wr && i_addr == a && !o_xlat_req && !$past(i_xlat_done);
    endsequence
    sequence s_walk_end;
        o_xlat_req && i_xlat_done;
    endsequence
    a_trig_starts:
        assert property (s_trig(smai_pkg::ADDR_TRIG_LO) |=> o_xlat_req)
        else $error("trigger write started no walk");
    a_trig_zext:
        assert property (s_trig(smai_pkg::ADDR_TRIG_LO) |=> o_xlat_addr ==
            {32'h0000_0000, $past(i_wdata[31:12]), 12'h000})
        else $error("walk address not zero extended");
    a_upper_ignored:
        assert property (s_trig(smai_pkg::ADDR_TRIG_HI) |=> !o_xlat_req)
        else $error("upper word write started a walk");
    a_req_holds:
        assert property (o_xlat_req && !i_xlat_done |=> o_xlat_req)
        else $error("walk request dropped early");
    a_walk_ends:
        assert property (s_walk_end |=> !o_xlat_req)
        else $error("walk request outlived done");
    a_addr_steady:
        assert property (o_xlat_req && !$rose(o_xlat_req) |->
            $stable(o_xlat_addr))
        else $error("walk address moved mid walk");
    a_status_busy:
        assert property (i_rd && i_addr == smai_pkg::ADDR_XLAT_STATUS &&
            o_xlat_req |=> o_rdata == 32'h0000_0001)
        else $error("status not active during walk");
    a_trig_rd_zero:
        assert property (i_rd && i_addr[11:3] == 9'h100 |=>
            o_rdata == 32'h0000_0000)
        else $error("trigger read not zero");
    a_dev_no_alloc:
        assert property (o_mem_type < 3'h4 |-> o_outer_pol == 2'h0 &&
            o_outer_alloc == 2'h0 && o_inner_alloc == 2'h0)
        else $error("device memory shows cache policy");
endmodule
bind smai_ctx_bank smai_ctx_bank_props smai_ctx_bank_props_inst (
    .i_core_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_mem_type, .o_outer_pol, .o_outer_alloc, .o_inner_alloc,
    .o_xlat_req, .o_xlat_addr, .i_xlat_done
);

// *** smai_ctx_bank_tb.sv ***
`timescale 1ns/1ps
module smai_ctx_bank_tb;
    logic        i_core_clk, i_srst, i_wr, i_rd, o_xlat_req, i_xlat_done;
    logic        o_outer_transient, o_inner_transient;
    logic        o_extended_address_enable;
    logic [11:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rd_val;
    logic [2:0]  i_attr_select_index, o_mem_type;
    logic [1:0]  o_outer_pol, o_inner_pol, o_outer_alloc, o_inner_alloc;
    logic [63:0] o_xlat_addr, i_xlat_result;
    logic [3:0]  walk_delay;
    int          errors, checks_done;

    smai_ctx_bank smai_ctx_bank_inst (.i_core_clk, .i_srst, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .i_attr_select_index,
        .o_mem_type, .o_outer_pol, .o_inner_pol, .o_outer_transient,
        .o_inner_transient, .o_outer_alloc, .o_inner_alloc, .o_xlat_req,
        .o_xlat_addr, .i_xlat_done, .i_xlat_result,
        .o_extended_address_enable);
    smai_walk_model smai_walk_model_inst (.i_core_clk, .i_srst,
        .i_req(o_xlat_req), .i_addr(o_xlat_addr), .i_delay(walk_delay),
        .o_done(i_xlat_done), .o_result(i_xlat_result));

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    // ==========================================
    // Bus and report helpers
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask
    task automatic end_sim;
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs;
        rd(smai_pkg::ADDR_XLAT_STATUS);
        chk("status_rst", 0, rd_val);
        wr(smai_pkg::ADDR_AUX_CTRL, 32'ha5c3_0f96);
        rd(smai_pkg::ADDR_AUX_CTRL);
        chk("aux", 32'ha5c3_0f96, rd_val);
        rd(12'h100);
        chk("unmapped", 0, rd_val);
        for (int b = 1; b >= 0; b--) begin
            wr(smai_pkg::ADDR_XLAT_CTRL, {b[0], 31'h0});
            chk("eae", b[0], o_extended_address_enable);
        end
    endtask
    task automatic t_attr;
        logic [12:0] e [8] = '{13'h0000, 13'h0400, 13'h0800, 13'h0c00,
                               13'h1140, 13'h13cf, 13'h12fa, 13'h128e};
        wr(smai_pkg::ADDR_ATTR_LOW, 32'h0c08_0400);
        wr(smai_pkg::ADDR_ATTR_HIGH, 32'hba26_ff44);
        for (int i = 0; i < 10; i++) begin
            if (i == 8) wr(smai_pkg::ADDR_ATTR_LOW, 32'h0000_4001);
            @(posedge i_core_clk);
            i_attr_select_index <= 3'(i);
            @(posedge i_core_clk);
            #1;
            if (i < 8) chk("attr", e[i], {o_mem_type, o_outer_pol,
                o_inner_pol, o_outer_transient, o_inner_transient,
                o_outer_alloc, o_inner_alloc});
            else chk("unpred", 3'h7, o_mem_type);
        end
    endtask
    task automatic t_walk(input logic [3:0] dly, input logic [31:0] d);
        @(posedge i_core_clk);
        walk_delay <= dly;
        i_addr <= smai_pkg::ADDR_TRIG_LO;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        // Second write lands while busy and must be dropped
        i_wdata <= ~d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
        chk("walk_addr", {32'h0, d[31:12], 12'h000}, o_xlat_addr);
        if (dly > 4'h3) begin
            rd(smai_pkg::ADDR_XLAT_STATUS);
            chk("status_busy", 1, rd_val);
        end
        for (int n = 0; o_xlat_req !== 1'b0; n++) begin
            if (n == 40) begin
                errors++;
                end_sim();
            end
            @(posedge i_core_clk);
            #1;
        end
        repeat (2) @(posedge i_core_clk);
        rd(smai_pkg::ADDR_XLAT_STATUS);
        chk("status_idle", 0, rd_val);
        rd(smai_pkg::ADDR_RESULT_HI);
        chk("result_hi", {d[31:12], 12'h000}, rd_val);
        rd(smai_pkg::ADDR_RESULT_LO);
        chk("result_lo", 32'h0000_0c01, rd_val);
    endtask
    task automatic t_upper;
        wr(smai_pkg::ADDR_TRIG_HI, 32'hffff_f000);
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("upper_req", 0, o_xlat_req);
        for (int i = 0; i < 2; i++) begin
            rd(smai_pkg::ADDR_TRIG_LO + 12'(4 * i));
            chk("trig_rd", 0, rd_val);
        end
    endtask

    initial begin
        i_srst = 1'b1;
        i_addr = 12'h000;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_attr_select_index = 3'h0;
        walk_delay = 4'h0;
        errors = 0;
        checks_done = 0;
        repeat (16) @(posedge i_core_clk);
        i_srst <= 1'b0;
        t_regs();
        t_attr();
        t_walk(4'h8, 32'hdead_beef);
        wr(smai_pkg::ADDR_XLAT_CTRL, 32'h8000_0000);
        t_walk(4'h0, 32'hffff_ffff);
        t_upper();
        end_sim();
    end
endmodule

// *** smai_pkg.sv ***
package smai_pkg;

    // Register offsets (byte addresses, one aligned word each)
    localparam logic [11:0] ADDR_ATTR_LOW    = 12'h038;
    localparam logic [11:0] ADDR_ATTR_HIGH   = 12'h03c;
    localparam logic [11:0] ADDR_XLAT_CTRL   = 12'h030;
    localparam logic [11:0] ADDR_AUX_CTRL    = 12'h004;
    localparam logic [11:0] ADDR_TRIG_LO     = 12'h800;
    localparam logic [11:0] ADDR_TRIG_HI     = 12'h804;
    localparam logic [11:0] ADDR_RESULT_LO   = 12'h050;
    localparam logic [11:0] ADDR_RESULT_HI   = 12'h054;
    localparam logic [11:0] ADDR_XLAT_STATUS = 12'h8f0;

    // Field positions
    localparam int EXT_ADDR_BIT  = 31;
    localparam int IDX_HI_BIT    = 2;
    localparam int BYTE_W        = 8;
    localparam int ADDR_LSB      = 12;
    localparam int STATUS_ACTIVE = 0;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Translation latency in core cycles
    localparam logic [3:0] XLAT_CYCLES = 4'h4;

    // Nibble encodings
    localparam logic [3:0] NIB_ZERO    = 4'h0;
    localparam logic [3:0] NIB_NONCACH = 4'h4;
    localparam logic [3:0] NIB_DEV_RO  = 4'h8;
    localparam logic [3:0] NIB_DEV_GRO = 4'hc;

    typedef enum logic [2:0] {
        SMAI_MEM_DEV_STRICT  = 3'h0,
        SMAI_MEM_DEV_EARLY   = 3'h1,
        SMAI_MEM_DEV_REORDER = 3'h2,
        SMAI_MEM_DEV_GATHER  = 3'h3,
        SMAI_MEM_NORMAL      = 3'h4,
        SMAI_MEM_UNPRED      = 3'h7
    } smai_mem_type_e;

    // Cache policy of one level
    typedef enum logic [1:0] {
        SMAI_CP_NONE = 2'h0,
        SMAI_CP_NC   = 2'h1,
        SMAI_CP_WT   = 2'h2,
        SMAI_CP_WB   = 2'h3
    } smai_cpol_e;

    typedef enum logic [1:0] {
        SMAI_XS_IDLE = 2'h0,
        SMAI_XS_BUSY = 2'h1,
        SMAI_XS_DONE = 2'h3
    } smai_xlat_state_e;

endpackage

// *** smai_walk_model.sv ***
`timescale 1ns/1ps
module smai_walk_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    input  wire logic        i_req,
    input  wire logic [63:0] i_addr,
    input  wire logic [3:0]  i_delay,
    output logic             o_done,
    output logic      [63:0] o_result
);
    // ==========================================
    // Table walk stand-in
    logic [3:0]  wait_q;
    logic [63:0] res;
    assign res      = {i_addr[31:0], 32'h0000_0c01};
    assign o_done   = i_req && (wait_q == i_delay);
    // Off the done pulse the bus shows garbage, never the result
    assign o_result = o_done ? res : ~res;
    always_ff @(posedge i_core_clk) begin
        if (i_srst || !i_req || o_done) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
